// File: otp_store_defs.svh
// Register offsets, store bit map, reset values and timing counts of the store controller
`ifndef OTP_STORE_DEFS_SVH
`define OTP_STORE_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_STORE_CTRL 5'h15
`define REG_STORE_STATUS 5'h16
`define REG_DIAG 5'h17
`define REG_CH1_TRIM 5'h1b
`define REG_CH2_TRIM 5'h1c
`define REG_SPARE_TRIM 5'h1d
`define REG_READOUT 5'h1e
`define REG_REVISION 5'h1f

// ----------------------------------------
// Register fields
// ----------------------------------------
`define CTRL_OP 1:0
`define CTRL_SLICE 3:2
`define STATUS_PROG_FAIL 0
`define DIAG_BUSY 4
`define PARITY_BIT 8

// ----------------------------------------
// Store bit map
// ----------------------------------------
`define F_CH1_VTHR 7:0
`define F_CH1_RANGE 9:8
`define F_CH2_VTHR 17:10
`define F_CH2_RANGE 19:18
`define F_CH1_TOFF 24:20
`define F_CH2_TOFF 29:25
`define F_CH1_EN 30
`define F_CH2_EN 31
`define F_FS_MODE 34:32
`define F_CH1_TAR 35
`define F_CH2_TAR 36
`define F_OC_THR 38:37
`define F_LOCK 39

// ----------------------------------------
// Operation codes and reset values
// ----------------------------------------
`define OP_REFRESH 2'h1
`define OP_PROGRAM 2'h2
`define READOUT_RESET 10'h000
`define SPARE_TEMPCO_RESET 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define REFRESH_TIME_NS 1000
`define PROG_TIME_NS 100000
`define REFRESH_CYCLES ((`REFRESH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES_DEFAULT (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: otp_store_pkg.sv
// Types of the one-time-programmable store controller
package otp_store_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REFRESH = 2'b01,
		ST_PROGRAM = 2'b10
	} store_state_type;

	typedef struct packed {
		store_state_type state;
		logic [15:0] cnt;
		logic boot;
		logic [39:0] array;
		logic [39:0] shadow;
		logic [9:0] readout;
		logic [1:0] slice;
		logic prog_fail;
		logic [9:0] rdata;
	} store_regs_type;

endpackage

// File: otp_config_store.sv
// Store controller with readout, trim and revision registers
//
// Summary of operation
// - Holds a 40-bit one-time-programmable store, programmed through the register port.
// - Store can be programmed once; a lock bit is burnt with it.
// - Refreshed store contents drive the configuration outputs, refreshed after power-up.
// - Bits 7..0/9..8 ch1 threshold/range; 17..10/19..18 ch2 threshold/range.
// - Ch1 off-time at bits 24..20, ch2 off-time at 29..25.
// - Ch1 enable bit 30, ch2 enable bit 31, fail-safe mode bits 34..32.
// - Thermal auto-recover bits 35, 36; overcurrent threshold 38..37; lock bit 39.
// - After refresh the readout holds slice 0..3 of the store, ten bits each.
// - Operation codes 0 and 3 start no operation; only the slice field of the write is taken.
// - Code 1 reloads all 40 bits and updates the readout when done.
// - Code 2 burns the mapped configuration plus the lock bit.
// - Programming is only allowed while the lock bit is clear.
// - Busy bit is high during the whole refresh or programming operation.
// - Trim registers carry odd parity at bit 8, bit 9 reads zero.
// - Register 0x1B holds ch1 coefficients, low ranges 3..0, high ranges 7..4.
// - Register 0x1C holds ch2 coefficients; 0x1D holds an unused zero field.
// - Coefficients are signed two's complement from -8 to 7.
// - Register 0x1F returns a 9-bit revision code with mask and tune fields.
// - Trim and revision values come from factory settings, not from reset.
// - Busy flag is bit 4 of diagnostics register 0x17, not latched.
// - Programming supply undervoltage latches a failure flag, cleared by reading.
`timescale 1ns/1ps
`include "otp_store_defs.svh"

module otp_config_store
	import otp_store_pkg::*;
#(
	parameter logic [15:0] PROG_CYCLES = 16'(`PROG_CYCLES_DEFAULT),
	parameter logic [39:0] STORE_IMAGE = 40'h00_0000_0000,
	parameter logic [7:0] CH1_TRIM = 8'h00,
	parameter logic [7:0] CH2_TRIM = 8'h00,
	// Arbitrary value, not a real part code
	parameter logic [8:0] REVISION_CODE = 9'h0a5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [9:0] reg_wdata,
	input wire logic reg_rd,
	output logic [9:0] reg_rdata,
	// Configuration registers to burn
	input wire logic [7:0] burn_ch1_voltage_threshold,
	input wire logic [1:0] burn_ch1_sense_range,
	input wire logic [7:0] burn_ch2_voltage_threshold,
	input wire logic [1:0] burn_ch2_sense_range,
	input wire logic [4:0] burn_ch1_off_time,
	input wire logic [4:0] burn_ch2_off_time,
	input wire logic burn_ch1_enable,
	input wire logic burn_ch2_enable,
	input wire logic [2:0] burn_failsafe_mode_select,
	input wire logic burn_ch1_thermal_auto_recover_en,
	input wire logic burn_ch2_thermal_auto_recover_en,
	input wire logic [1:0] burn_overcurrent_compare_threshold,
	// Programming supply monitor
	input wire logic prog_supply_low,
	// Stored configuration
	output logic [7:0] ch1_voltage_threshold,
	output logic [1:0] ch1_sense_range,
	output logic [7:0] ch2_voltage_threshold,
	output logic [1:0] ch2_sense_range,
	output logic [4:0] ch1_off_time,
	output logic [4:0] ch2_off_time,
	output logic ch1_enable,
	output logic ch2_enable,
	output logic [2:0] failsafe_mode_select,
	output logic ch1_thermal_auto_recover_en,
	output logic ch2_thermal_auto_recover_en,
	output logic [1:0] overcurrent_compare_threshold,
	output logic store_locked,
	// Status and trim coefficients
	output logic store_busy,
	output logic signed [3:0] ch1_tempco_low_ranges,
	output logic signed [3:0] ch1_tempco_high_ranges,
	output logic signed [3:0] ch2_tempco_low_ranges,
	output logic signed [3:0] ch2_tempco_high_ranges,
	output logic signed [3:0] spare_tempco
);

	store_regs_type s;
	store_regs_type next_s;
	logic [9:0] read_value;
	logic [1:0] op;
	logic ctrl_wr;

	function automatic logic [9:0] slice_of(input logic [39:0] word, input logic [1:0] sel);
		case (sel)
			2'h0: slice_of = word[9:0];
			2'h1: slice_of = word[19:10];
			2'h2: slice_of = word[29:20];
			default: slice_of = word[39:30];
		endcase
	endfunction

	function automatic logic [9:0] with_parity(input logic [7:0] bits);
		with_parity = {1'b0, ~^bits, bits};
	endfunction

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb begin
		case (reg_addr)
			`REG_STORE_CTRL: read_value = {6'h00, s.slice, 2'h0};
			`REG_STORE_STATUS: read_value = with_parity({7'h00, s.prog_fail});
			`REG_DIAG: read_value = with_parity({3'h0, s.state != ST_IDLE, 4'h0});
			`REG_CH1_TRIM: read_value = with_parity(CH1_TRIM);
			`REG_CH2_TRIM: read_value = with_parity(CH2_TRIM);
			`REG_SPARE_TRIM: read_value = with_parity({4'h0, `SPARE_TEMPCO_RESET});
			`REG_READOUT: read_value = s.readout;
			`REG_REVISION: read_value = {1'b0, REVISION_CODE};
			default: read_value = 10'h000;
		endcase
	end

	assign ctrl_wr = reg_wr && reg_addr == `REG_STORE_CTRL;
	assign op = reg_wdata[`CTRL_OP];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		if (reg_rd) begin
			next_s.rdata = read_value;
			if (reg_addr == `REG_STORE_STATUS) begin
				next_s.prog_fail = 1'b0;
			end
		end
		case (s.state)
			ST_IDLE: begin
				// Control writes act only here, so busy operations run undisturbed
				if (ctrl_wr) begin
					// Slice is applied at the end of the next refresh
					next_s.slice = reg_wdata[`CTRL_SLICE];
				end
				// Codes 0 and 3 match no branch and leave store and readout alone
				if (s.boot) begin
					next_s.boot = 1'b0;
					next_s.state = ST_REFRESH;
					next_s.cnt = 16'(`REFRESH_CYCLES - 1);
				end else if (ctrl_wr && op == `OP_REFRESH) begin
					next_s.state = ST_REFRESH;
					next_s.cnt = 16'(`REFRESH_CYCLES - 1);
				end else if (ctrl_wr && op == `OP_PROGRAM && !s.array[`F_LOCK]) begin
					next_s.state = ST_PROGRAM;
					next_s.cnt = PROG_CYCLES - 16'h0001;
				end
			end
			ST_REFRESH: begin
				next_s.cnt = s.cnt - 16'h0001;
				if (s.cnt == 16'h0000) begin
					next_s.state = ST_IDLE;
					next_s.shadow = s.array;
					next_s.readout = slice_of(s.array, s.slice);
				end
			end
			ST_PROGRAM: begin
				next_s.cnt = s.cnt - 16'h0001;
				// Undervoltage only flags the failure; the burn still completes
				if (prog_supply_low) begin
					next_s.prog_fail = 1'b1;
				end
				if (s.cnt == 16'h0000) begin
					next_s.state = ST_IDLE;
					next_s.array = {1'b1, burn_overcurrent_compare_threshold,
						burn_ch2_thermal_auto_recover_en, burn_ch1_thermal_auto_recover_en,
						burn_failsafe_mode_select, burn_ch2_enable, burn_ch1_enable,
						burn_ch2_off_time, burn_ch1_off_time,
						burn_ch2_sense_range, burn_ch2_voltage_threshold,
						burn_ch1_sense_range, burn_ch1_voltage_threshold};
				end
			end
			default: begin
				next_s.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s.state <= ST_IDLE;
			s.cnt <= 16'h0000;
			s.boot <= 1'b1;
			s.array <= STORE_IMAGE;
			s.shadow <= 40'h00_0000_0000;
			s.readout <= `READOUT_RESET;
			s.slice <= 2'h0;
			s.prog_fail <= 1'b0;
			s.rdata <= 10'h000;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = s.rdata;
	assign store_busy = s.state != ST_IDLE;
	assign ch1_voltage_threshold = s.shadow[`F_CH1_VTHR];
	assign ch1_sense_range = s.shadow[`F_CH1_RANGE];
	assign ch2_voltage_threshold = s.shadow[`F_CH2_VTHR];
	assign ch2_sense_range = s.shadow[`F_CH2_RANGE];
	assign ch1_off_time = s.shadow[`F_CH1_TOFF];
	assign ch2_off_time = s.shadow[`F_CH2_TOFF];
	assign ch1_enable = s.shadow[`F_CH1_EN];
	assign ch2_enable = s.shadow[`F_CH2_EN];
	assign failsafe_mode_select = s.shadow[`F_FS_MODE];
	assign ch1_thermal_auto_recover_en = s.shadow[`F_CH1_TAR];
	assign ch2_thermal_auto_recover_en = s.shadow[`F_CH2_TAR];
	assign overcurrent_compare_threshold = s.shadow[`F_OC_THR];
	assign store_locked = s.shadow[`F_LOCK];
	assign ch1_tempco_low_ranges = signed'(CH1_TRIM[3:0]);
	assign ch1_tempco_high_ranges = signed'(CH1_TRIM[7:4]);
	assign ch2_tempco_low_ranges = signed'(CH2_TRIM[3:0]);
	assign ch2_tempco_high_ranges = signed'(CH2_TRIM[7:4]);
	assign spare_tempco = signed'(`SPARE_TEMPCO_RESET);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int REFRESH_BOUND = 51;

	sequence start_refresh;
		s.state == ST_IDLE && !s.boot && ctrl_wr && op == `OP_REFRESH;
	endsequence

	sequence start_program;
		s.state == ST_IDLE && !s.boot && ctrl_wr && op == `OP_PROGRAM;
	endsequence

	busy_tracks_state_a: assert property (@(posedge clk) disable iff (!nrst)
		$past(s.state) == ST_IDLE && s.state != ST_IDLE |-> store_busy throughout (s.state != ST_IDLE) [*3])
		else $error("busy dropped during operation");
	refresh_bounded_a: assert property (@(posedge clk) disable iff (!nrst)
		start_refresh |=> store_busy ##[1:REFRESH_BOUND] !store_busy)
		else $error("refresh did not finish in time");
	readout_slice_a: assert property (@(posedge clk) disable iff (!nrst)
		$fell(store_busy) && $past(s.state) == ST_REFRESH |-> s.readout == s.shadow[10 * s.slice +: 10])
		else $error("readout does not match selected slice");
	nop_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
		s.state == ST_IDLE && !s.boot && ctrl_wr && (op == 2'h0 || op == 2'h3)
		|=> s.state == ST_IDLE && $stable(s.readout) && $stable(s.array))
		else $error("no-operation code changed state");
	locked_no_prog_a: assert property (@(posedge clk) disable iff (!nrst)
		start_program and s.array[`F_LOCK] |=> s.state == ST_IDLE)
		else $error("programming started on locked store");
	prog_sets_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		$past(s.state) == ST_PROGRAM && s.state == ST_IDLE |-> s.array[`F_LOCK])
		else $error("lock bit not burnt");
	busy_ignores_op_a: assert property (@(posedge clk) disable iff (!nrst)
		s.state == ST_REFRESH && s.cnt != 16'h0000 && ctrl_wr |=> s.state == ST_REFRESH && $stable(s.slice))
		else $error("operation accepted while busy");
	trim_parity_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && (reg_addr == `REG_CH1_TRIM || reg_addr == `REG_CH2_TRIM)
		|=> ^reg_rdata[8:0] && !reg_rdata[9])
		else $error("trim parity wrong");
	fail_latched_a: assert property (@(posedge clk) disable iff (!nrst)
		s.state == ST_PROGRAM && prog_supply_low |=> s.prog_fail)
		else $error("undervoltage not latched");
	diag_busy_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == `REG_DIAG |=> reg_rdata[`DIAG_BUSY] == $past(store_busy))
		else $error("diagnostics busy bit wrong");

	sequence refresh_last;
		s.state == ST_REFRESH && s.cnt == 16'h0000;
	endsequence

	sequence program_last;
		s.state == ST_PROGRAM && s.cnt == 16'h0000;
	endsequence

	// Boot refresh loads the power-up configuration
	boot_refresh_a: assert property (@(posedge clk) disable iff (!nrst)
		s.boot |=> s.state == ST_REFRESH && !s.boot)
		else $error("no refresh after reset");
	shadow_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		s.state != ST_REFRESH |=> $stable(s.shadow))
		else $error("configuration changed outside refresh");
	readout_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		s.state != ST_REFRESH |=> $stable(s.readout))
		else $error("readout changed outside refresh");
	refresh_reload_a: assert property (@(posedge clk) disable iff (!nrst)
		refresh_last |=> !store_busy && s.shadow == $past(s.array))
		else $error("refresh did not reload the store");
	program_end_a: assert property (@(posedge clk) disable iff (!nrst)
		program_last |=> !store_busy)
		else $error("busy stayed after programming");
	burn_map_a: assert property (@(posedge clk) disable iff (!nrst)
		program_last |=> s.array[`F_CH1_VTHR] == $past(burn_ch1_voltage_threshold)
		&& s.array[`F_CH2_TOFF] == $past(burn_ch2_off_time)
		&& s.array[`F_FS_MODE] == $past(burn_failsafe_mode_select)
		&& s.array[`F_OC_THR] == $past(burn_overcurrent_compare_threshold))
		else $error("burnt word does not follow the bit map");
	fail_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == `REG_STORE_STATUS && s.state != ST_PROGRAM |=> !s.prog_fail)
		else $error("failure flag not cleared by read");
	revision_read_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == `REG_REVISION |=> reg_rdata == {1'b0, REVISION_CODE})
		else $error("revision code wrong");

endmodule

// File: reg_host.sv
// Register host model driving the store controller's register port
`timescale 1ns/1ps

module reg_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [4:0] reg_addr,
	output logic reg_wr,
	output logic [9:0] reg_wdata,
	output logic reg_rd,
	input wire logic [9:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 10'h000;
		reg_rd = 1'b0;
	end

	// Released lines flip so stale values never pass
	task automatic wr(input logic [4:0] a, input logic [9:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	task automatic rd(input logic [4:0] a, output logic [9:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		#1;
		v = reg_rdata;
	endtask
endmodule

// File: otp_config_store_tb_top.sv
// Self-checking bench of the store controller
`timescale 1ns/1ps
`include "otp_store_defs.svh"

module otp_config_store_tb_top;
	localparam logic [39:0] IMAGE = 40'h00_9c3a_5e71;
	localparam logic [7:0] TRIM1 = 8'h78;
	localparam logic [7:0] TRIM2 = 8'h9e;
	// Arbitrary value, not a real part code
	localparam logic [8:0] REV = 9'h0c3;
	logic clk;
	logic nrst;
	logic [4:0] reg_addr;
	logic reg_wr;
	logic [9:0] reg_wdata;
	logic reg_rd;
	logic [9:0] reg_rdata;
	logic [38:0] burn;
	logic prog_supply_low;
	logic store_busy;
	wire [39:0] cfg;
	wire [19:0] tc;
	logic [39:0] mdl;
	logic [31:0] seed;
	logic [9:0] d;
	int n;
	int n_fail;
	int tests_run;

	// --------
	// Host and design
	// --------
	reg_host i_reg_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	otp_config_store #(.PROG_CYCLES(16'd8), .STORE_IMAGE(IMAGE), .CH1_TRIM(TRIM1), .CH2_TRIM(TRIM2),
		.REVISION_CODE(REV)) i_otp_config_store (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.burn_ch1_voltage_threshold(burn[7:0]), .burn_ch1_sense_range(burn[9:8]),
		.burn_ch2_voltage_threshold(burn[17:10]), .burn_ch2_sense_range(burn[19:18]),
		.burn_ch1_off_time(burn[24:20]), .burn_ch2_off_time(burn[29:25]), .burn_ch1_enable(burn[30]),
		.burn_ch2_enable(burn[31]), .burn_failsafe_mode_select(burn[34:32]),
		.burn_ch1_thermal_auto_recover_en(burn[35]), .burn_ch2_thermal_auto_recover_en(burn[36]),
		.burn_overcurrent_compare_threshold(burn[38:37]), .prog_supply_low(prog_supply_low),
		.ch1_voltage_threshold(cfg[7:0]), .ch1_sense_range(cfg[9:8]), .ch2_voltage_threshold(cfg[17:10]),
		.ch2_sense_range(cfg[19:18]), .ch1_off_time(cfg[24:20]), .ch2_off_time(cfg[29:25]),
		.ch1_enable(cfg[30]), .ch2_enable(cfg[31]), .failsafe_mode_select(cfg[34:32]),
		.ch1_thermal_auto_recover_en(cfg[35]), .ch2_thermal_auto_recover_en(cfg[36]),
		.overcurrent_compare_threshold(cfg[38:37]), .store_locked(cfg[39]), .store_busy(store_busy),
		.ch1_tempco_low_ranges(tc[3:0]), .ch1_tempco_high_ranges(tc[7:4]), .ch2_tempco_low_ranges(tc[11:8]),
		.ch2_tempco_high_ranges(tc[15:12]), .spare_tempco(tc[19:16]));

	// --------
	// Checking tasks
	// --------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic test_done();
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Counts busy cycles, bounded wait
	task automatic idle(output int c);
		c = 0;
		for (int i = 0; i < 300; i++) begin
			#1;
			if (store_busy === 1'b1) c++;
			else if (c > 0 || i > 3) break;
			@(posedge clk);
		end
	endtask

	task automatic sweep();
		int c;
		for (int s = 0; s < 4; s++) begin
			i_reg_host.wr(`REG_STORE_CTRL, {6'h00, 2'(s), `OP_REFRESH});
			idle(c);
			chk(40'(c), 40'(`REFRESH_CYCLES));
			i_reg_host.rd(`REG_READOUT, d);
			chk(40'(d), 40'(mdl[10*s+:10]));
		end
		chk(cfg, mdl);
	endtask

	task automatic prog(output int c);
		@(posedge clk);
		seed = lfsr(seed);
		burn <= {seed[6:0], lfsr(seed)};
		i_reg_host.wr(`REG_STORE_CTRL, 10'(`OP_PROGRAM));
		prog_supply_low <= 1'b1;
		idle(c);
		@(posedge clk);
		prog_supply_low <= 1'b0;
	endtask

	// --------
	// Test sequence
	// --------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#400000;
		n_fail++;
		test_done();
	end

	initial begin
		nrst = 1'b0;
		burn = '0;
		prog_supply_low = 1'b0;
		n_fail = 0;
		tests_run = 0;
		seed = 32'h6a81;
		mdl = IMAGE;
		@(posedge clk);
		#1;
		chk(40'({store_busy, reg_rdata}), 40'h0);
		chk(cfg, 40'h0);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		idle(n);
		chk(40'(n), 40'(`REFRESH_CYCLES));
		chk(cfg, mdl);
		$display("test boot done");
		i_reg_host.wr(`REG_CH1_TRIM, 10'h2a5);
		i_reg_host.rd(`REG_CH1_TRIM, d);
		chk(40'(d), 40'({1'b0, ~^TRIM1, TRIM1}));
		i_reg_host.rd(`REG_CH2_TRIM, d);
		chk(40'(d), 40'({1'b0, ~^TRIM2, TRIM2}));
		i_reg_host.rd(`REG_SPARE_TRIM, d);
		chk(40'(d), 40'h100);
		i_reg_host.rd(`REG_REVISION, d);
		chk(40'(d), 40'({1'b0, REV}));
		i_reg_host.rd(5'h03, d);
		chk(40'(d), 40'h0);
		chk(40'(signed'(tc[3:0])), 40'(-8));
		chk(40'(signed'(tc[7:4])), 40'(7));
		chk(40'(tc[19:8]), 40'({`SPARE_TEMPCO_RESET, TRIM2}));
		$display("test trim done");
		sweep();
		for (int k = 0; k < 2; k++) begin
			i_reg_host.wr(`REG_STORE_CTRL, {6'h00, 2'h1, 2'(3 * k)});
			idle(n);
			chk(40'(n), 40'h0);
			i_reg_host.rd(`REG_READOUT, d);
			chk(40'(d), 40'(mdl[39:30]));
		end
		$display("test refresh done");
		i_reg_host.wr(`REG_STORE_CTRL, 10'h005);
		i_reg_host.rd(`REG_DIAG, d);
		chk(40'(d[`DIAG_BUSY]), 40'h1);
		i_reg_host.wr(`REG_STORE_CTRL, 10'h00a);
		idle(n);
		i_reg_host.rd(`REG_READOUT, d);
		chk(40'(d), 40'(mdl[19:10]));
		i_reg_host.rd(`REG_DIAG, d);
		chk(40'(d[`DIAG_BUSY]), 40'h0);
		$display("test busy done");
		prog(n);
		chk(40'(n), 40'h8);
		mdl = {1'b1, burn};
		i_reg_host.rd(`REG_STORE_STATUS, d);
		chk(40'(d[`STATUS_PROG_FAIL]), 40'h1);
		i_reg_host.rd(`REG_STORE_STATUS, d);
		chk(40'(d[`STATUS_PROG_FAIL]), 40'h0);
		sweep();
		prog(n);
		chk(40'(n), 40'h0);
		sweep();
		$display("test program done");
		test_done();
	end
endmodule
